// file: dpc_consts.svh
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

// reset values of the working state
`define COUNT_RESET '0
`define COORD_RESET '0
`define PHASE_RESET 2'h0

// nonvolatile read sequence: issue, wait, capture
`define PHASE_ISSUE 2'h0
`define PHASE_CAPTURE 2'h2

`endif

// file: dpc_pkg.sv
package dpc_pkg;

	localparam int COORD_W = 12;
	localparam int PIX_W   = 12;
	localparam int ENTRY_W = 2 * COORD_W;

	typedef logic [COORD_W-1:0] coord_t;
	typedef logic [PIX_W-1:0]   pixel_t;

	typedef struct packed {
		coord_t col;
		coord_t row;
	} entry_t;

	typedef struct packed {
		pixel_t data;
		logic   sof;
		logic   eol;
	} pix_t;

	typedef struct packed {
		logic   valid;
		logic   sof;
		logic   eol;
		logic   hit;
		pixel_t data;
	} stage_t;

	typedef enum logic [1:0] {
		METHOD_AVERAGE,
		METHOD_HIGHLIGHT,
		METHOD_ZERO
	} method_t;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_BOOT,
		SEQ_APPLY,
		SEQ_SAVE,
		SEQ_RESTORE
	} seq_state_t;

endpackage

// file: pixel_fifo.sv
`timescale 1ns/1ps
`include "dpc_consts.svh"

module pixel_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	// filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// draining side
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0]   count;
	logic [PTR_W:0]   next_count;
	logic             push;
	logic             pop;

	assign push      = in_valid & in_ready;
	assign out_valid = (count != '0);
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + (PTR_W+1)'(1);
		end else if (pop && !push) begin
			next_count = count - (PTR_W+1)'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
			end
		end
	end

	// registered ready keeps the filling side off a combinational path
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count    <= '0;
			in_ready <= 1'b1;
		end else begin
			count    <= next_count;
			in_ready <= (next_count != (PTR_W+1)'(DEPTH));
		end
	end

endmodule

// file: defective_pixel_correction.sv
`timescale 1ns/1ps
`include "dpc_consts.svh"

// Operation
// [R1] One enable turns table correction on or off, and when off every pixel passes unchanged.
// [R2] In average mode each listed pixel is replaced by the mean of its neighbours.
// [R3] In highlight mode each listed pixel is replaced by the largest pixel value.
// [R4] A writable entry count says how many table entries are used for correction.
// [R5] A zero-based index from zero to count minus one selects one table entry.
// [R6] Column and row of the selected entry can be read and written, a write touching only it.
// [R7] Table coordinates are full-sensor positions, so the region offsets are added to stream positions.
// [R8] Edits reach the pixel path only after the commit command, and then govern it.
// [R9] Commit loads only the volatile working table, which a power loss wipes unless saved.
// [R10] The persist command writes the table to nonvolatile storage, which is loaded at every boot.
// [R11] Persisting overwrites whatever table was stored before.
// [R12] The restore command puts the calibrated list into the working table and the stored table.
// [R13] During a commit or restore the pixel path may briefly correct wrongly until the copy ends.
// [R14] A calibrated defect list is built in, and software may change or replace it.
// [R15] Software adds an entry by raising the count, pointing the index at it, writing it, then committing.
// [R16] Averaging uses the same-colour pixels two columns left and right, or the one that exists at an edge.
// [R17] Coordinate writes at or past the count are ignored and the count is clamped to the table size.
module defective_pixel_correction import dpc_pkg::*; #(
	parameter int                     DEPTH         = 16,
	parameter int                     FIFO_DEPTH    = 32,
	parameter int                     FACTORY_COUNT = 0,
	parameter logic [DEPTH*ENTRY_W-1:0] FACTORY_LIST = '0
) (
	// clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          reset,
	// pixel stream in
	input  wire pix_t                          in_pix,
	input  wire logic                          in_valid,
	output logic                               in_ready,
	// pixel stream out
	output pix_t                               out_pix,
	output logic                               out_valid,
	input  wire logic                          out_ready,
	// output region placement on the sensor
	input  wire coord_t                        region_col_offset,
	input  wire coord_t                        region_row_offset,
	// correction control
	input  wire logic                          table_correction_enable,
	input  wire method_t                       replacement_method,
	// table editing
	input  wire logic                          entry_count_write,
	input  wire logic [$clog2(DEPTH+1)-1:0]    entry_count_value,
	output logic      [$clog2(DEPTH+1)-1:0]    entry_count,
	input  wire logic [$clog2(DEPTH+1)-1:0]    entry_index,
	input  wire logic                          entry_column_write,
	input  wire logic                          entry_row_write,
	input  wire coord_t                        entry_coord_value,
	output coord_t                             entry_column,
	output coord_t                             entry_row,
	// table commands
	input  wire logic                          commit_table,
	input  wire logic                          persist_table,
	input  wire logic                          restore_calibrated_table,
	output logic                               table_busy,
	// nonvolatile table store
	input  wire logic                          nv_holds_table,
	input  wire entry_t                        nv_rdata,
	output logic                               nv_read,
	output logic                               nv_write,
	output logic      [$clog2(DEPTH+1)-1:0]    nv_addr,
	output entry_t                             nv_wdata
);

	localparam int CNT_W     = $clog2(DEPTH + 1);
	localparam int IDX_W     = $clog2(DEPTH);
	localparam int APPLY_CYC = DEPTH + 1;

	entry_t           edit_tab [DEPTH];
	entry_t           act_tab [DEPTH];
	entry_t           factory_tab [DEPTH];
	logic [CNT_W-1:0] edit_count;
	logic [CNT_W-1:0] act_count;

	seq_state_t       state;
	logic [CNT_W-1:0] seq_idx;
	logic [1:0]       phase;
	logic             restore_nv;
	logic             step;
	logic             at_count;
	logic             load_edit;
	logic             load_act;
	logic [IDX_W-1:0] ent_idx;
	entry_t           src_entry;
	logic [CNT_W-1:0] src_count;

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_factory
			assign factory_tab[g] = FACTORY_LIST[g*ENTRY_W +: ENTRY_W]; // [R14]
		end
	endgenerate

	// table copy sequencer sources
	assign ent_idx  = seq_idx[IDX_W-1:0];
	assign at_count = (seq_idx == CNT_W'(DEPTH));
	assign step     = (state == SEQ_BOOT) ? (phase == `PHASE_CAPTURE)
	                                      : (state != SEQ_IDLE);

	always_comb begin
		src_entry = edit_tab[ent_idx];
		src_count = edit_count;
		if (state == SEQ_BOOT) begin
			src_entry = nv_rdata; // [R10]
			src_count = (nv_rdata.col > coord_t'(DEPTH)) ? CNT_W'(DEPTH)
			                                             : nv_rdata.col[CNT_W-1:0];
		end else if (state == SEQ_RESTORE) begin
			src_entry = factory_tab[ent_idx]; // [R12]
			src_count = CNT_W'(FACTORY_COUNT);
		end
	end

	assign load_edit = step & ((state == SEQ_BOOT) | (state == SEQ_RESTORE));
	assign load_act  = step & (state != SEQ_SAVE); // [R9]

	// sequencer: boot load, commit, persist, restore, one entry a cycle, boot load one entry every three cycles
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state      <= SEQ_BOOT;
			table_busy <= 1'b1;
			seq_idx    <= '0;
			phase      <= `PHASE_RESET;
			restore_nv <= 1'b0;
		end else begin
			case (state)
				SEQ_IDLE: begin
					seq_idx <= '0;
					if (restore_calibrated_table) begin
						state      <= SEQ_RESTORE;
						restore_nv <= 1'b1; // [R12]
						table_busy <= 1'b1;
					end else if (commit_table) begin
						state      <= SEQ_APPLY; // [R8]
						table_busy <= 1'b1;
					end else if (persist_table) begin
						state      <= SEQ_SAVE; // [R10]
						table_busy <= 1'b1;
					end
				end
				SEQ_BOOT: begin
					if (seq_idx == '0 && phase == `PHASE_ISSUE && !nv_holds_table) begin
						state      <= SEQ_RESTORE; // [R14]
						restore_nv <= 1'b0;
					end else begin
						phase <= (phase == `PHASE_CAPTURE) ? `PHASE_ISSUE : phase + 2'h1;
					end
				end
				default: begin
				end
			endcase
			if (step) begin
				if (at_count) begin
					state      <= SEQ_IDLE;
					table_busy <= 1'b0;
				end else begin
					seq_idx <= seq_idx + CNT_W'(1);
				end
			end
		end
	end

	// nonvolatile store port
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			nv_read  <= 1'b0;
			nv_write <= 1'b0;
			nv_addr  <= '0;
			nv_wdata <= '0;
		end else begin
			nv_read  <= (state == SEQ_BOOT) && (phase == `PHASE_ISSUE) && nv_holds_table;
			nv_write <= (state == SEQ_SAVE) || (state == SEQ_RESTORE && restore_nv); // [R11]
			nv_addr  <= seq_idx;
			nv_wdata <= at_count ? entry_t'{col: coord_t'(src_count), row: '0} : src_entry;
		end
	end

	// working table seen by the pixel path
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			act_count <= `COUNT_RESET;
		end else if (load_act) begin
			if (at_count) begin
				act_count <= src_count; // [R8]
			end else begin
				act_tab[ent_idx] <= src_entry; // [R13]
			end
		end
	end

	// host edits, held off while a copy runs
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			edit_count <= `COUNT_RESET;
		end else if (load_edit) begin
			if (at_count) begin
				edit_count <= src_count;
			end else begin
				edit_tab[ent_idx] <= src_entry;
			end
		end else if (state == SEQ_IDLE) begin
			if (entry_count_write) begin
				edit_count <= (entry_count_value > CNT_W'(DEPTH)) ? CNT_W'(DEPTH)
				                                                   : entry_count_value; // [R4] [R17]
			end
			if (entry_index < edit_count) begin // [R5] [R17]
				if (entry_column_write) begin
					edit_tab[entry_index[IDX_W-1:0]].col <= entry_coord_value; // [R6]
				end
				if (entry_row_write) begin
					edit_tab[entry_index[IDX_W-1:0]].row <= entry_coord_value; // [R6]
				end
			end
		end
	end

	// readback of the selected entry
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			entry_count  <= `COUNT_RESET;
			entry_column <= `COORD_RESET;
			entry_row    <= `COORD_RESET;
		end else begin
			entry_count <= edit_count;
			if (entry_index < edit_count) begin
				entry_column <= edit_tab[entry_index[IDX_W-1:0]].col; // [R6]
				entry_row    <= edit_tab[entry_index[IDX_W-1:0]].row;
			end else begin
				entry_column <= `COORD_RESET;
				entry_row    <= `COORD_RESET;
			end
		end
	end

	// pixel path
	pix_t             fifo_pix;
	logic             fifo_valid;
	logic             fifo_take;
	stage_t           win [5];
	stage_t           new_stage;
	logic             flush;
	logic             advance;
	coord_t           cur_col;
	coord_t           cur_row;
	coord_t           pix_col;
	coord_t           pix_row;
	entry_t           abs_pos;
	logic [DEPTH-1:0] hit_vec;
	pixel_t           fixed;
	logic [PIX_W:0]   pair_sum;

	pixel_fifo #(
		.WIDTH ($bits(pix_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.in_data   (in_pix),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.out_data  (fifo_pix),
		.out_valid (fifo_valid),
		.out_ready (fifo_take)
	);

	// line end is flushed with bubbles so neighbours never cross lines
	assign flush     = (win[0].valid & win[0].eol) | (win[1].valid & win[1].eol)
	                 | (win[2].valid & win[2].eol);
	assign advance   = (!out_valid || out_ready) && (flush || fifo_valid);
	assign fifo_take = advance & !flush;

	assign pix_col     = fifo_pix.sof ? '0 : cur_col;
	assign pix_row     = fifo_pix.sof ? '0 : cur_row;
	assign abs_pos.col = pix_col + region_col_offset; // [R7]
	assign abs_pos.row = pix_row + region_row_offset; // [R7]

	generate
		for (g = 0; g < DEPTH; g++) begin : g_match
			assign hit_vec[g] = (CNT_W'(g) < act_count) && (act_tab[g] == abs_pos); // [R4] [R8]
		end
	endgenerate

	always_comb begin
		new_stage = '0;
		if (!flush) begin
			new_stage.valid = 1'b1;
			new_stage.sof   = fifo_pix.sof;
			new_stage.eol   = fifo_pix.eol;
			new_stage.hit   = |hit_vec;
			new_stage.data  = fifo_pix.data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cur_col <= '0;
			cur_row <= '0;
		end else if (fifo_take) begin
			cur_col <= fifo_pix.eol ? '0 : pix_col + coord_t'(1);
			cur_row <= fifo_pix.eol ? pix_row + coord_t'(1) : pix_row;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < 5; i++) begin
				win[i] <= '0;
			end
		end else if (advance) begin
			win[0] <= new_stage;
			for (int i = 1; i < 5; i++) begin
				win[i] <= win[i-1];
			end
		end
	end

	assign pair_sum = {1'b0, win[0].data} + {1'b0, win[4].data};

	always_comb begin
		fixed = win[2].data;
		if (table_correction_enable && win[2].hit) begin // [R1]
			case (replacement_method)
				METHOD_AVERAGE: begin
					if (win[0].valid && win[4].valid) begin
						fixed = pair_sum[PIX_W:1]; // [R2]
					end else if (win[4].valid) begin
						fixed = win[4].data; // [R16]
					end else if (win[0].valid) begin
						fixed = win[0].data; // [R16]
					end
				end
				METHOD_HIGHLIGHT: fixed = '1; // [R3]
				METHOD_ZERO:      fixed = '0;
				default:          fixed = win[2].data;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			out_valid <= 1'b0;
			out_pix   <= '0;
		end else if (advance) begin
			out_valid    <= win[2].valid;
			out_pix.data <= fixed;
			out_pix.sof  <= win[2].sof;
			out_pix.eol  <= win[2].eol;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	pass_through_a: assert property ( // [R1]
		advance && win[2].valid && !table_correction_enable |=> out_pix.data == $past(win[2].data)
	) else $error("disabled correction altered a pixel");

	average_value_a: assert property ( // [R2]
		advance && win[2].valid && win[2].hit && table_correction_enable
		&& replacement_method == METHOD_AVERAGE && win[0].valid && win[4].valid
		|=> out_pix.data == pixel_t'(({1'b0, $past(win[0].data)} + $past(win[4].data)) >> 1)
	) else $error("averaged pixel wrong");

	highlight_max_a: assert property ( // [R3]
		advance && win[2].valid && win[2].hit && table_correction_enable
		&& replacement_method == METHOD_HIGHLIGHT |=> out_valid && out_pix.data == '1
	) else $error("highlighted pixel not at maximum");

	count_clamp_a: assert property ( // [R17]
		##1 edit_count <= CNT_W'(DEPTH)
	) else $error("entry count above table size");

	commit_length_a: assert property ( // [R13]
		state == SEQ_IDLE && commit_table && !restore_calibrated_table
		|-> ##APPLY_CYC state == SEQ_APPLY ##1 state == SEQ_IDLE && !table_busy
	) else $error("commit copy took wrong time");

	commit_count_a: assert property ( // [R8]
		state == SEQ_APPLY && at_count |=> act_count == $past(edit_count)
	) else $error("commit did not load count");

	idle_stable_a: assert property ( // [R8]
		state == SEQ_IDLE && $past(state) == SEQ_IDLE |-> $stable(act_count)
	) else $error("working count changed without a command");

	commit_volatile_a: assert property ( // [R9]
		state == SEQ_APPLY |=> !nv_write
	) else $error("commit wrote nonvolatile store");

	persist_write_a: assert property ( // [R10]
		state == SEQ_SAVE |=> nv_write && nv_addr == $past(seq_idx)
	) else $error("persist step missed a store write");

	restore_both_a: assert property ( // [R12]
		state == SEQ_RESTORE && at_count
		|=> act_count == CNT_W'(FACTORY_COUNT) && edit_count == CNT_W'(FACTORY_COUNT)
	) else $error("restore did not load calibrated count");

	commit_done_c: cover property (state == SEQ_APPLY && at_count);
	persist_done_c: cover property (state == SEQ_SAVE && at_count);
	highlight_out_c: cover property (advance && win[2].hit && replacement_method == METHOD_HIGHLIGHT);
	edge_average_c: cover property (advance && win[2].hit && !win[4].valid && win[0].valid);

endmodule

// file: nv_table_store.sv
`timescale 1ns/1ps

module nv_table_store import dpc_pkg::*; #(
	parameter int DEPTH = 4
) (
	// clock
	input  wire logic                       ref_clk,
	// store port
	input  wire logic                       nv_read,
	input  wire logic                       nv_write,
	input  wire logic [$clog2(DEPTH+1)-1:0] nv_addr,
	input  wire entry_t                     nv_wdata,
	output entry_t                          nv_rdata,
	output logic                            nv_holds_table
);
	entry_t mem [0:DEPTH];

	initial begin
		nv_holds_table = 1'b0;
		nv_rdata = '0;
	end

	// contents survive device resets, as the real store would
	always @(posedge ref_clk) begin
		if (nv_write === 1'b1) begin
			mem[nv_addr] <= nv_wdata;
			if (nv_addr == DEPTH)
				nv_holds_table <= 1'b1;
		end
		// one cycle of valid data, then scrambled so stale reads show
		if (nv_read === 1'b1)
			nv_rdata <= mem[nv_addr];
		else
			nv_rdata <= ~nv_rdata;
	end
endmodule

// file: test_defective_pixel_correction.sv
`timescale 1ns/1ps

module test_defective_pixel_correction;
	import dpc_pkg::*;
	localparam int D = 4;
	localparam int CW = $clog2(D+1);
	localparam int W = 8;
	localparam logic [D*ENTRY_W-1:0] FLIST = {D{12'h005, 12'h001}};

	logic          ref_clk, reset, in_valid, in_ready, out_valid;
	logic          out_ready = 1'b0;
	pix_t          in_pix, out_pix;
	coord_t        offc, offr, coord_val, rd_col, rd_row;
	logic          en, cnt_wr, col_wr, row_wr, commit, persist, restore, busy;
	method_t       meth;
	logic [CW-1:0] cnt_val, cnt_rd, idx, nv_addr;
	logic          nv_read, nv_write, nv_holds;
	entry_t        nv_rdata, nv_wdata;
	int            errors = 0;
	int            check_count = 0;
	int            nv_writes = 0;
	int            cyc = 0;
	int            ecnt;
	int            ecol [D];
	int            erow [D];
	pix_t          got [$];

	defective_pixel_correction #(.DEPTH(D), .FIFO_DEPTH(32), .FACTORY_COUNT(1),
		.FACTORY_LIST(FLIST)) u_dut (
		.ref_clk(ref_clk), .reset(reset), .in_pix(in_pix), .in_valid(in_valid),
		.in_ready(in_ready), .out_pix(out_pix), .out_valid(out_valid), .out_ready(out_ready),
		.region_col_offset(offc), .region_row_offset(offr),
		.table_correction_enable(en), .replacement_method(meth),
		.entry_count_write(cnt_wr), .entry_count_value(cnt_val), .entry_count(cnt_rd),
		.entry_index(idx), .entry_column_write(col_wr), .entry_row_write(row_wr),
		.entry_coord_value(coord_val), .entry_column(rd_col), .entry_row(rd_row),
		.commit_table(commit), .persist_table(persist),
		.restore_calibrated_table(restore), .table_busy(busy),
		.nv_holds_table(nv_holds), .nv_rdata(nv_rdata), .nv_read(nv_read),
		.nv_write(nv_write), .nv_addr(nv_addr), .nv_wdata(nv_wdata));

	nv_table_store #(.DEPTH(D)) u_store (
		.ref_clk(ref_clk), .nv_read(nv_read), .nv_write(nv_write), .nv_addr(nv_addr),
		.nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .nv_holds_table(nv_holds));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// sink stalls every third cycle
	always @(posedge ref_clk) begin
		#1 out_ready = (cyc % 3) != 0;
		cyc++;
	end

	always @(posedge ref_clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1)
			got.push_back(out_pix);
		if (nv_write === 1'b1)
			nv_writes++;
	end

	task check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task complete_run;
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task tick;
		@(posedge ref_clk);
		#1;
	endtask

	function pixel_t px(int c, int r);
		return pixel_t'(12'h040 + 3 * c * c + 32 * r);
	endfunction

	function pixel_t exp_px(int c, int r);
		int hit;
		hit = 0;
		for (int i = 0; i < ecnt; i++)
			if (ecol[i] == c + offc && erow[i] == r + offr)
				hit = 1;
		if (!en || !hit)
			return px(c, r);
		if (meth == METHOD_HIGHLIGHT)
			return 12'hfff;
		if (meth == METHOD_ZERO)
			return 12'h000;
		if (c >= 2 && c + 2 < W)
			return pixel_t'((int'(px(c - 2, r)) + int'(px(c + 2, r))) / 2);
		if (c >= 2)
			return px(c - 2, r);
		if (c + 2 < W)
			return px(c + 2, r);
		return px(c, r);
	endfunction

	task do_reset;
		reset = 1'b1;
		tick;
		tick;
		reset = 1'b0;
	endtask

	task wait_idle;
		tick;
		for (int k = 0; k < 300 && busy !== 1'b0; k++)
			tick;
		// readback and the last store write trail busy by one cycle
		tick;
		check("table_busy", busy, 0);
	endtask

	// 0 commit, 1 persist, 2 restore
	task cmd(int k);
		case (k)
			0: commit = 1'b1;
			1: persist = 1'b1;
			default: restore = 1'b1;
		endcase
		tick;
		commit = 1'b0;
		persist = 1'b0;
		restore = 1'b0;
		wait_idle;
	endtask

	task set_count(int v);
		cnt_val = CW'(v);
		cnt_wr = 1'b1;
		tick;
		cnt_wr = 1'b0;
		tick;
		tick;
	endtask

	task set_entry(int i, int c, int r);
		idx = CW'(i);
		coord_val = coord_t'(c);
		col_wr = 1'b1;
		tick;
		col_wr = 1'b0;
		coord_val = coord_t'(r);
		row_wr = 1'b1;
		tick;
		row_wr = 1'b0;
		tick;
		tick;
	endtask

	task expect_entry(int i, int c, int r);
		idx = CW'(i);
		repeat (3) tick;
		check("entry column", rd_col, c);
		check("entry row", rd_row, r);
	endtask

	task run_frame(string what);
		got.delete();
		for (int r = 0; r < 2; r++)
			for (int c = 0; c < W; c++) begin
				in_pix = '{data: px(c, r), sof: (r == 0 && c == 0), eol: (c == W - 1)};
				in_valid = 1'b1;
				@(posedge ref_clk);
				while (in_ready !== 1'b1)
					@(posedge ref_clk);
				#1;
			end
		in_valid = 1'b0;
		for (int k = 0; k < 500 && got.size() < 2 * W; k++)
			tick;
		check({what, " count"}, got.size(), 2 * W);
		for (int i = 0; i < got.size() && i < 2 * W; i++) begin
			check(what, got[i].data, exp_px(i % W, i / W));
			check({what, " sof"}, got[i].sof, i == 0);
			check({what, " eol"}, got[i].eol, i % W == W - 1);
		end
	endtask

	task t_boot_factory;
		wait_idle;
		check("boot count", cnt_rd, 1);
		check("boot store writes", nv_writes, 0);
		expect_entry(0, 5, 1);
	endtask

	task t_modes;
		for (int m = 0; m < 3; m++) begin
			meth = method_t'(m);
			run_frame("corrected");
		end
		en = 1'b0;
		run_frame("bypass");
		en = 1'b1;
		meth = METHOD_AVERAGE;
	endtask

	task t_add_entry;
		set_count(2);
		check("edit count", cnt_rd, 2);
		set_entry(1, 7, 0);
		expect_entry(1, 7, 0);
		expect_entry(0, 5, 1);
		run_frame("uncommitted");
		cmd(0);
		ecnt = 2;
		ecol[1] = 7;
		erow[1] = 0;
		run_frame("committed");
		set_entry(3, 2, 2);
		set_count(7);
		check("clamped count", cnt_rd, D);
		expect_entry(3, 5, 1);
		set_count(2);
	endtask

	task t_offset;
		offc = 12'h002;
		offr = 12'h001;
		run_frame("offset region");
		offc = 12'h000;
		offr = 12'h000;
	endtask

	task t_persist_boot;
		int w0;
		w0 = nv_writes;
		cmd(1);
		check("saved words", nv_writes - w0, D + 1);
		check("saved count", u_store.mem[D].col, 2);
		check("saved entry", u_store.mem[1], {12'h007, 12'h000});
		set_count(3);
		cmd(0);
		do_reset;
		wait_idle;
		check("boot count", cnt_rd, 2);
		expect_entry(1, 7, 0);
		run_frame("boot from store");
	endtask

	task t_restore;
		cmd(2);
		check("restored count", cnt_rd, 1);
		check("stored count", u_store.mem[D].col, 1);
		expect_entry(0, 5, 1);
		ecnt = 1;
		run_frame("factory table");
	endtask

	initial begin
		reset = 1'b1;
		in_valid = 1'b0;
		in_pix = '0;
		offc = '0;
		offr = '0;
		coord_val = '0;
		en = 1'b1;
		meth = METHOD_AVERAGE;
		{cnt_wr, col_wr, row_wr, commit, persist, restore} = '0;
		cnt_val = '0;
		idx = '0;
		ecnt = 1;
		ecol[0] = 5;
		erow[0] = 1;
		repeat (2) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		t_boot_factory;
		t_modes;
		t_add_entry;
		t_offset;
		t_persist_boot;
		t_restore;
		complete_run;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		complete_run;
	end
endmodule
